//--- rtl/can_mode_map.svh
// offsets, field positions, reset values and mode codes for the can
// control block; assumes a 32-bit axi4-lite slave, one word a register
// Operation
// R1: halt-in-idle set stops the controller while the device idles.
// R2: abort-all aborts every pending transmit; hardware clears it when done.
// R3: clock select 1 gives controller clock twice peripheral, else equal.
// R4: requested mode codes: 111,100,011,010,001,000; 110 and 101 reserved.
// R5: read-only current mode field reports the mode in force, same codes.
// R6: reset puts both mode fields at configuration; other bits zero.
// R7: capture enable makes each received message raise a capture event.
// R8: window select steers shared map to filters when 1, buffers when 0.
// R9: buffer word four holds byte 2 low, byte 3 high, no reset.
// R10: buffer word five holds byte 4 low, byte 5 high, no reset.
// R11: current mode updates only after the requested switch has happened.
`ifndef CAN_MODE_MAP_SVH
`define CAN_MODE_MAP_SVH
`define OFS_CTRL 8'h00
`define OFS_WORD_FOUR 8'h04
`define OFS_WORD_FIVE 8'h08
`define OFS_STATUS 8'h0c
`define BIT_HALT_IDLE 13
`define BIT_ABORT 12
`define BIT_CLK_SEL 11
`define REQ_HI 10
`define REQ_LO 8
`define CUR_HI 7
`define CUR_LO 5
`define BIT_CAP_EN 3
`define BIT_WINDOW 0
`define MODE_LISTEN_ALL 3'h7
`define MODE_RSV_A 3'h6
`define MODE_RSV_B 3'h5
`define MODE_CONFIG 3'h4
`define MODE_LISTEN_ONLY 3'h3
`define MODE_LOOPBACK 3'h2
`define MODE_DISABLE 3'h1
`define MODE_NORMAL 3'h0
`define RESET_MODE 3'h4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- rtl/can_mode_pkg.sv
// types shared by the can control block
// assumes can_mode_map.svh is on the include path
package can_mode_pkg;
	`include "can_mode_map.svh"
	typedef logic [2:0] mode_code_type;
	typedef logic [15:0] reg_word_type;
	typedef enum logic {SEQ_STABLE, SEQ_SWITCH} seq_state_type;
	function automatic logic is_reserved_mode(input mode_code_type m);
		is_reserved_mode = (m == `MODE_RSV_A) || (m == `MODE_RSV_B);
	endfunction
endpackage

//--- rtl/can_word_store.sv
// small array of 16-bit words with byte-lane writes, no reset
// assumes writer gives index, data and two byte strobes
`timescale 1ns/10ps
module can_word_store #(
	parameter int WORDS = 2
) (
	// clock
	input wire logic aclk,
	// write port
	input wire logic wr_en,
	input wire logic [$clog2(WORDS)-1:0] wr_idx,
	input wire can_mode_pkg::reg_word_type wr_data,
	input wire logic [1:0] wr_strb,
	// read port
	input wire logic [$clog2(WORDS)-1:0] rd_idx,
	output can_mode_pkg::reg_word_type rd_data
);
	import can_mode_pkg::*;
	reg_word_type mem_ff [WORDS];
	reg_word_type nxt_word;
	if (WORDS < 2) $error("word store needs two words");
	// low lane is the even byte, high lane the odd byte
	always_comb
	begin
		nxt_word = mem_ff[wr_idx];
		if (wr_strb[0])
			nxt_word[7:0] = wr_data[7:0]; // [R9] [R10]
		if (wr_strb[1])
			nxt_word[15:8] = wr_data[15:8]; // [R9] [R10]
	end
	always_ff @(posedge aclk)
	begin
		if (wr_en)
			mem_ff[wr_idx] <= nxt_word;
	end
	assign rd_data = mem_ff[rd_idx];
endmodule // can_word_store

//--- rtl/can_mode_seq.sv
// mode switch sequencer: moves current mode to requested at frame idle
// assumes frame_idle is high while the protocol engine sits between frames
`timescale 1ns/10ps
`include "can_mode_map.svh"
module can_mode_seq (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// request and link state
	input wire can_mode_pkg::mode_code_type req_mode,
	input wire logic frame_idle,
	// state
	output can_mode_pkg::mode_code_type cur_mode,
	output logic switching
);
	import can_mode_pkg::*;
	seq_state_type state_ff, nxt_state;
	mode_code_type cur_ff, nxt_cur;
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cur = cur_ff;
		unique case (state_ff)
			SEQ_STABLE:
				if (req_mode != cur_ff)
					nxt_state = SEQ_SWITCH;
			SEQ_SWITCH:
				if (frame_idle)
				begin
					nxt_cur = req_mode; // [R11] [R5]
					nxt_state = SEQ_STABLE;
				end
		endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_ff <= SEQ_STABLE;
			cur_ff <= `RESET_MODE; // [R6]
		end
		else
		begin
			state_ff <= nxt_state;
			cur_ff <= nxt_cur;
		end
	end
	assign cur_mode = cur_ff;
	assign switching = (state_ff == SEQ_SWITCH);
endmodule // can_mode_seq

//--- rtl/can_mode_ctrl.sv
// can control register, mode sequencing and buffer words 4/5 behind
// an axi4-lite slave; assumes a protocol engine reporting frame idle,
// pending transmit buffers and received messages
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "can_mode_map.svh"
module can_mode_ctrl #(
	parameter int TX_BUFFERS = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// device and engine status
	input wire logic device_idle,
	input wire logic frame_idle,
	input wire logic [TX_BUFFERS-1:0] tx_pending,
	input wire logic rx_msg_done,
	// controls to the engine
	output logic controller_run,
	output logic abort_all_transmit,
	output logic controller_clock_double,
	output logic window_filter,
	output can_mode_pkg::mode_code_type active_mode,
	output logic capture_event
);
	import can_mode_pkg::*;
	if (TX_BUFFERS < 1 || TX_BUFFERS > 24)
		$error("tx buffer count out of range");

	// control bits
	logic halt_in_idle_ff, nxt_halt_in_idle;
	logic abort_ff, nxt_abort;
	logic clk_sel_ff, nxt_clk_sel;
	mode_code_type req_ff, nxt_req;
	logic cap_en_ff, nxt_cap_en;
	logic window_ff, nxt_window;
	// axi state
	logic awready_ff, nxt_awready;
	logic wready_ff, nxt_wready;
	logic arready_ff, nxt_arready;
	logic [7:0] waddr_ff, nxt_waddr;
	logic [15:0] wdata_ff, nxt_wdata;
	logic [1:0] wstrb_ff, nxt_wstrb;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] rresp_ff, nxt_rresp;
	// engine-facing outputs
	logic run_ff, nxt_run;
	logic capture_ff, nxt_capture;
	mode_code_type mode_out_ff, nxt_mode_out;
	// internals
	mode_code_type cur_mode;
	logic switching;
	logic do_write;
	logic word_sel;
	reg_word_type buf_rd, flt_rd;
	logic buf_wr, flt_wr;

	function automatic logic is_shared(input logic [7:0] a);
		is_shared = (a == `OFS_WORD_FOUR) || (a == `OFS_WORD_FIVE);
	endfunction
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == `OFS_CTRL) || is_shared(a) ||
			(a == `OFS_STATUS);
	endfunction

	assign do_write = !awready_ff && !wready_ff && !bvalid_ff;
	assign word_sel = (waddr_ff == `OFS_WORD_FIVE);
	// shared offsets reach filters or buffers by window
	assign buf_wr = do_write && is_shared(waddr_ff) && !window_ff; // [R8]
	assign flt_wr = do_write && is_shared(waddr_ff) && window_ff; // [R8]

	can_word_store #(.WORDS(2)) buffer_words (
		.aclk(aclk),
		.wr_en(buf_wr),
		.wr_idx(word_sel),
		.wr_data(wdata_ff),
		.wr_strb(wstrb_ff),
		.rd_idx(araddr == `OFS_WORD_FIVE),
		.rd_data(buf_rd)
	);
	can_word_store #(.WORDS(2)) filter_words (
		.aclk(aclk),
		.wr_en(flt_wr),
		.wr_idx(word_sel),
		.wr_data(wdata_ff),
		.wr_strb(wstrb_ff),
		.rd_idx(araddr == `OFS_WORD_FIVE),
		.rd_data(flt_rd)
	);
	can_mode_seq mode_seq (
		.aclk(aclk),
		.aresetn(aresetn),
		.req_mode(req_ff),
		.frame_idle(frame_idle),
		.cur_mode(cur_mode),
		.switching(switching)
	);

	// control register writes and hardware clears
	always_comb
	begin
		nxt_halt_in_idle = halt_in_idle_ff;
		nxt_abort = abort_ff;
		nxt_clk_sel = clk_sel_ff;
		nxt_req = req_ff;
		nxt_cap_en = cap_en_ff;
		nxt_window = window_ff;
		if (abort_ff && tx_pending == '0)
			nxt_abort = 1'b0; // [R2]
		if (do_write && waddr_ff == `OFS_CTRL)
		begin
			if (wstrb_ff[1])
			begin
				nxt_halt_in_idle = wdata_ff[`BIT_HALT_IDLE];
				if (wdata_ff[`BIT_ABORT])
					nxt_abort = 1'b1; // [R2]
				nxt_clk_sel = wdata_ff[`BIT_CLK_SEL]; // [R3]
				if (!is_reserved_mode(wdata_ff[`REQ_HI:`REQ_LO]))
					nxt_req = wdata_ff[`REQ_HI:`REQ_LO]; // [R4]
			end
			if (wstrb_ff[0])
			begin
				nxt_cap_en = wdata_ff[`BIT_CAP_EN];
				nxt_window = wdata_ff[`BIT_WINDOW];
			end
		end
	end

	// engine-facing outputs
	always_comb
	begin
		nxt_run = !(halt_in_idle_ff && device_idle) &&
			(cur_mode != `MODE_DISABLE); // [R1]
		nxt_capture = cap_en_ff && rx_msg_done; // [R7]
		nxt_mode_out = cur_mode;
	end

	// axi write channel
	always_comb
	begin
		nxt_awready = awready_ff;
		nxt_wready = wready_ff;
		nxt_waddr = waddr_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb = wstrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		if (awvalid && awready_ff)
		begin
			nxt_awready = 1'b0;
			nxt_waddr = awaddr;
		end
		if (wvalid && wready_ff)
		begin
			nxt_wready = 1'b0;
			nxt_wdata = wdata[15:0];
			nxt_wstrb = wstrb[1:0];
		end
		if (do_write)
		begin
			nxt_bvalid = 1'b1;
			nxt_bresp = is_mapped(waddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (bvalid_ff && bready)
		begin
			nxt_bvalid = 1'b0;
			nxt_awready = 1'b1;
			nxt_wready = 1'b1;
		end
	end

	// axi read channel
	always_comb
	begin
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		if (arvalid && !rvalid_ff)
		begin
			nxt_rvalid = 1'b1;
			nxt_rresp = `RESP_OKAY;
			nxt_rdata = 32'h0000_0000;
			unique case (araddr)
				`OFS_CTRL:
				begin
					nxt_rdata[`BIT_HALT_IDLE] = halt_in_idle_ff;
					nxt_rdata[`BIT_ABORT] = abort_ff;
					nxt_rdata[`BIT_CLK_SEL] = clk_sel_ff;
					nxt_rdata[`REQ_HI:`REQ_LO] = req_ff;
					nxt_rdata[`CUR_HI:`CUR_LO] = cur_mode; // [R5]
					nxt_rdata[`BIT_CAP_EN] = cap_en_ff;
					nxt_rdata[`BIT_WINDOW] = window_ff;
				end
				`OFS_WORD_FOUR, `OFS_WORD_FIVE:
					nxt_rdata[15:0] = window_ff ? flt_rd : buf_rd; // [R8]
				`OFS_STATUS:
				begin
					nxt_rdata[0] = switching;
					nxt_rdata[1] = run_ff;
					nxt_rdata[TX_BUFFERS+7:8] = tx_pending;
				end
				default:
					nxt_rresp = `RESP_SLVERR;
			endcase
		end
		else if (rvalid_ff && rready)
			nxt_rvalid = 1'b0;
		nxt_arready = !nxt_rvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			halt_in_idle_ff <= 1'b0; // [R6]
			abort_ff <= 1'b0;
			clk_sel_ff <= 1'b0;
			req_ff <= `RESET_MODE; // [R6]
			cap_en_ff <= 1'b0;
			window_ff <= 1'b0;
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			arready_ff <= 1'b1;
			waddr_ff <= 8'h00;
			wdata_ff <= 16'h0000;
			wstrb_ff <= 2'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `RESP_OKAY;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= `RESP_OKAY;
			run_ff <= 1'b0;
			capture_ff <= 1'b0;
			mode_out_ff <= `RESET_MODE;
		end
		else
		begin
			halt_in_idle_ff <= nxt_halt_in_idle;
			abort_ff <= nxt_abort;
			clk_sel_ff <= nxt_clk_sel;
			req_ff <= nxt_req;
			cap_en_ff <= nxt_cap_en;
			window_ff <= nxt_window;
			awready_ff <= nxt_awready;
			wready_ff <= nxt_wready;
			arready_ff <= nxt_arready;
			waddr_ff <= nxt_waddr;
			wdata_ff <= nxt_wdata;
			wstrb_ff <= nxt_wstrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
			run_ff <= nxt_run;
			capture_ff <= nxt_capture;
			mode_out_ff <= nxt_mode_out;
		end
	end

	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign controller_run = run_ff;
	assign abort_all_transmit = abort_ff;
	assign controller_clock_double = clk_sel_ff;
	assign window_filter = window_ff;
	assign active_mode = mode_out_ff;
	assign capture_event = capture_ff;

	halt_idle_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
		halt_in_idle_ff && device_idle |=> !controller_run)
		else $error("controller runs while halted in idle");
	abort_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
		abort_ff && tx_pending == '0 && !do_write |=> !abort_all_transmit)
		else $error("abort not cleared after all aborted");
	abort_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
		abort_ff && tx_pending != '0 |=> abort_all_transmit)
		else $error("abort dropped with transmits pending");
	clk_sel_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
		do_write && waddr_ff == `OFS_CTRL && wstrb_ff[1]
		|=> controller_clock_double == $past(wdata_ff[`BIT_CLK_SEL]))
		else $error("clock select not taken");
	req_legal_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
		!is_reserved_mode(req_ff))
		else $error("reserved mode requested");
	mode_reset_a: assert property (@(posedge aclk) // [R6]
		!aresetn |=> cur_mode == `MODE_CONFIG && req_ff == `MODE_CONFIG)
		else $error("mode not configuration after reset");
	capture_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
		rx_msg_done |=> capture_event == $past(cap_en_ff))
		else $error("capture event wrong");
	mode_switch_a: assert property (@(posedge aclk) // [R11]
		disable iff (!aresetn)
		$changed(cur_mode) |-> $past(frame_idle) && cur_mode == $past(req_ff))
		else $error("mode changed without switch point");
	mode_report_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
		arvalid && arready && araddr == `OFS_CTRL
		|=> rdata[`CUR_HI:`CUR_LO] == $past(cur_mode))
		else $error("current mode misreported");
endmodule // can_mode_ctrl

//--- testbench/can_engine_model.sv
// protocol engine stand-in: frame idle, pending transmits, receive pulses
// assumes the bench picks prompt or slow behaviour through slow
`timescale 1ns/10ps
module can_engine_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// controls
	input wire logic abort_all_transmit,
	input wire logic slow,
	input wire logic rx_go,
	// engine status
	output logic frame_idle,
	output logic [7:0] tx_pending,
	output logic rx_msg_done
);
	logic [2:0] cnt_ff;
	// slow: busy in frames half the time, one buffer aborts a cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_ff <= 3'h0;
			frame_idle <= 1'b1;
			tx_pending <= 8'h3c;
			rx_msg_done <= 1'b0;
		end
		else
		begin
			cnt_ff <= cnt_ff + 3'h1;
			frame_idle <= !slow || cnt_ff[2];
			rx_msg_done <= rx_go;
			if (abort_all_transmit)
				tx_pending <= slow ? tx_pending & (tx_pending - 8'h1) : 8'h00;
		end
	end
endmodule // can_engine_model

//--- testbench/tb_top.sv
// self-checking bench for the can control block over axi4-lite
// assumes can_engine_model stands in for the protocol engine
`timescale 1ns/10ps
module tb_top;
	import can_mode_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr, tx_pending;
	logic [31:0] wdata, rdata, d, v, w;
	logic [3:0] wstrb;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, r;
	logic device_idle, frame_idle, rx_msg_done, slow, rx_go;
	logic controller_run, abort_all_transmit, controller_clock_double;
	logic window_filter, capture_event;
	mode_code_type active_mode, e, m;
	mode_code_type codes [8] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h3, 3'h5, 3'h7, 3'h4};
	int error_cnt, n_checks, cap_cnt, seed, k, c0;

	can_mode_ctrl dut_u (.aclk, .aresetn, .awvalid, .awready, .awaddr,
		.wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
		.arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
		.device_idle, .frame_idle, .tx_pending, .rx_msg_done,
		.controller_run, .abort_all_transmit, .controller_clock_double,
		.window_filter, .active_mode, .capture_event);
	can_engine_model engine_u (.aclk, .aresetn, .abort_all_transmit,
		.slow, .rx_go, .frame_idle, .tx_pending, .rx_msg_done);

	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	always @(posedge aclk)
		if (capture_event === 1'b1)
			cap_cnt++;

	task automatic chk(input string nm, input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dt,
		input logic [3:0] s, output logic [1:0] rs);
		int t;
		@(posedge aclk);
		awaddr <= a;
		wdata <= dt;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		t = 0;
		do
		begin
			@(posedge aclk);
			t++;
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && t < 100);
		rs = bresp;
		bready <= 1'b0;
		if (t >= 100)
		begin
			error_cnt++;
			end_sim;
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] dt,
		output logic [1:0] rs);
		int t;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		t = 0;
		do
		begin
			@(posedge aclk);
			t++;
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && t < 100);
		dt = rdata;
		rs = rresp;
		rready <= 1'b0;
		if (t >= 100)
		begin
			error_cnt++;
			end_sim;
		end
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		#1000000;
		error_cnt++;
		end_sim;
	end

	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{device_idle, rx_go} = 2'h0;
		slow = 1'b1;
		seed = 32'h540a;
		aresetn = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		// reset state
		rd(8'h00, d, r);
		chk("ctrl reset", d, 32'h480);
		chk("mode reset", active_mode, 3'h4);
		$display("reset test done");
		// abort all with a slow engine
		wr(8'h00, 32'h1400, 4'h2, r);
		chk("abort set", abort_all_transmit, 1'b1);
		for (k = 0; k < 60 && abort_all_transmit !== 1'b0; k++)
			@(posedge aclk);
		chk("abort done", tx_pending, 8'h00);
		rd(8'h00, d, r);
		chk("abort clear", d[12], 1'b0);
		$display("abort test done");
		// every mode code, reserved ones refused
		e = 3'h4;
		for (int i = 0; i < 8; i++)
		begin
			m = codes[i];
			slow <= i[0];
			if (m != 3'h6 && m != 3'h5)
				e = m;
			wr(8'h00, {21'h0, m, 8'h0}, 4'h2, r);
			for (k = 0; k < 40; k++)
			begin
				rd(8'h00, d, r);
				if (d[7:5] === e)
					break;
			end
			chk("req mode", d[10:8], e);
			chk("cur mode", d[7:5], e);
			repeat (2) @(posedge aclk);
			chk("active mode", active_mode, e);
			chk("run in mode", controller_run, e != 3'h1);
		end
		$display("mode test done");
		// random control bits, idle halt and capture
		for (int i = 0; i < 8; i++)
		begin
			v = $random(seed);
			device_idle <= v[1];
			wr(8'h00, (v & 32'h2809) | 32'h400, 4'h3, r);
			chk("clock sel", controller_clock_double, v[11]);
			chk("window", window_filter, v[0]);
			rd(8'h00, d, r);
			chk("ctrl read", d, (v & 32'h2809) | 32'h480);
			chk("run idle", controller_run, !(v[13] & v[1]));
			rd(8'h0c, d, r);
			chk("status", d, {30'h0, !(v[13] & v[1]), 1'b0});
			c0 = cap_cnt;
			rx_go <= 1'b1;
			@(posedge aclk);
			rx_go <= 1'b0;
			repeat (3) @(posedge aclk);
			chk("capture", cap_cnt - c0, v[3]);
		end
		device_idle <= 1'b0;
		wr(8'h00, 32'h400, 4'h3, r);
		$display("control test done");
		// buffer words, full and low-byte writes
		for (int i = 0; i < 6; i++)
		begin
			v = $random(seed);
			wr(i[0] ? 8'h08 : 8'h04, v, 4'hf, r);
			rd(i[0] ? 8'h08 : 8'h04, d, r);
			chk("word full", d, {16'h0, v[15:0]});
			wr(i[0] ? 8'h08 : 8'h04, ~v, 4'h1, r);
			rd(i[0] ? 8'h08 : 8'h04, w, r);
			chk("word low", w, {16'h0, v[15:8], ~v[7:0]});
		end
		// filter window must not disturb the buffer word
		wr(8'h00, 32'h401, 4'h3, r);
		wr(8'h08, ~w, 4'hf, r);
		rd(8'h08, d, r);
		chk("filter word", d, {16'h0, ~w[15:0]});
		wr(8'h00, 32'h400, 4'h3, r);
		rd(8'h08, d, r);
		chk("window steer", d, w);
		// unmapped place
		wr(8'h10, v, 4'hf, r);
		chk("bresp unmapped", r, 2'h2);
		rd(8'h10, d, r);
		chk("rresp unmapped", r, 2'h2);
		chk("rdata unmapped", d, 32'h0);
		$display("buffer test done");
		end_sim;
	end
endmodule // tb_top
